// file: e1rc_apb_host.sv
`timescale 1ns/1ps
module e1rc_apb_host (
  // Clock.
  input  wire logic        clk,
  // APB request.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [13:0]      paddr,
  output logic [31:0]      pwdata,
  // APB answer.
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
  end

  // One transfer; the request is held until pready is seen high at an edge.
  task automatic xfer(input logic wr, input logic [13:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// file: e1rc_pkg.sv
package e1rc_pkg;

  localparam int          NUM_CHAN      = 22;
  localparam logic [4:0]  LAST_CHAN_BLK = 5'h14;
  localparam logic [5:0]  CHAN0_BLK     = 6'h1f;

  // Register indices inside one channel block; byte address is four times the index.
  localparam logic [5:0]  REG_SAMPLE    = 6'h09;
  localparam logic [5:0]  REG_CFG       = 6'h0a;
  localparam logic [5:0]  REG_TPL_CTRL  = 6'h3e;
  localparam logic [5:0]  REG_TPL_READ  = 6'h3f;

  localparam logic [6:0]  SAMPLE_RST    = 7'h00;
  localparam logic [7:0]  CFG_RST       = 8'h47;
  localparam logic [11:0] CTRL_RST      = 12'h000;

  localparam int          CFG_HOLD_BIT  = 7;
  localparam int          CFG_FLOAT_BIT = 6;
  localparam int          CFG_OFF_BIT   = 5;
  localparam int          CFG_FULL_BIT  = 4;
  localparam int          CFG_SING_BIT  = 3;
  localparam int          CFG_TERM_LSB  = 0;

  localparam int          CTRL_IDX_LSB  = 0;
  localparam int          CTRL_DIR_BIT  = 5;
  localparam int          CTRL_EN_BIT   = 6;
  localparam int          CTRL_TPL_LSB  = 8;
  localparam int          CTRL_ARB_BIT  = 11;

  localparam int          RAM_DEPTH     = 20;
  localparam logic [4:0]  RAM_LAST      = 5'h13;

  typedef enum logic [1:0] {
    MATCH_RESERVED,
    MATCH_INT_120,
    MATCH_INT_75,
    MATCH_EXTERNAL
  } e1rc_match_t;

endpackage

// file: e1rc_regs.sv
`timescale 1ns/1ps
module e1rc_regs
  import e1rc_pkg::*;
(
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // APB slave.
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [13:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  // Global receive settings and pins.
  input  wire logic                          per_channel_match_en,
  input  wire logic                          reference_master_clock,
  // Per-channel receive path inputs.
  input  wire logic [NUM_CHAN-1:0]           line_signal_loss,
  input  wire logic [NUM_CHAN-1:0]           rx_alarm_pattern_on,
  input  wire logic [NUM_CHAN-1:0]           rx_recovered_clock_in,
  input  wire logic [NUM_CHAN-1:0]           rx_positive_rail_in,
  input  wire logic [NUM_CHAN-1:0]           rx_negative_rail_in,
  input  wire logic [NUM_CHAN-1:0]           rx_multifunction_in,
  // Per-channel system side outputs.
  output logic [NUM_CHAN-1:0]                recovered_clock_out,
  output logic [NUM_CHAN-1:0]                rx_positive_rail_out,
  output logic [NUM_CHAN-1:0]                rx_negative_rail_out,
  output logic [NUM_CHAN-1:0]                rx_multifunction_out,
  output logic [NUM_CHAN-1:0]                rx_outputs_oe,
  // Per-channel line interface settings.
  output logic [NUM_CHAN-1:0]                rx_power_down,
  output logic [NUM_CHAN-1:0]                single_ended_rx,
  output logic [NUM_CHAN-1:0]                full_internal_match,
  output e1rc_match_t [NUM_CHAN-1:0]         rx_match_mode,
  // Template RAM read port for the waveform engine.
  input  wire logic [4:0]                    tpl_rd_chan,
  input  wire logic [4:0]                    tpl_rd_addr,
  output logic [6:0]                         tpl_rd_data
);

  // Returns {valid, channel} for a word index.
  function automatic logic [5:0] chan_decode(input logic [11:0] idx);
    logic [5:0] res;
    res = 6'h00;
    if (idx[11:6] == CHAN0_BLK) begin
      res = 6'h20;
    end else if (!idx[11] && idx[10:6] <= LAST_CHAN_BLK) begin
      res = {1'b1, idx[10:6] + 5'h01};
    end
    return res;
  endfunction

  function automatic logic [4:0] ram_map(input logic [4:0] sel);
    return (sel >= RAM_LAST) ? RAM_LAST : sel;
  endfunction

  function automatic e1rc_match_t match_decode(input logic [7:0] cfg_v);
    e1rc_match_t m;
    m = MATCH_RESERVED;
    if (cfg_v[CFG_SING_BIT] || cfg_v[CFG_TERM_LSB+2]) begin
      m = MATCH_EXTERNAL;
    end else if (cfg_v[CFG_TERM_LSB+1]) begin
      m = cfg_v[CFG_TERM_LSB] ? MATCH_INT_75 : MATCH_INT_120;
    end
    return m;
  endfunction

  logic [6:0]  sample      [NUM_CHAN];
  logic [7:0]  cfg         [NUM_CHAN];
  logic [11:0] ctrl        [NUM_CHAN];
  logic [6:0]  ram         [NUM_CHAN][RAM_DEPTH];
  logic [6:0]  next_sample [NUM_CHAN];
  logic [7:0]  next_cfg    [NUM_CHAN];
  logic [11:0] next_ctrl   [NUM_CHAN];
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [6:0]  next_tpl_rd_data;
  logic        ref_meta;
  logic        ref_sync;
  logic [5:0]  dec;
  logic [4:0]  acc_chan;
  logic [5:0]  acc_reg;
  logic        acc_hit;
  logic        wr;
  logic        ram_we;
  logic        ram_rd_en;
  logic [4:0]  ram_addr;
  logic [31:0] rd_value;

  assign dec      = chan_decode(paddr[13:2]);
  assign acc_chan = dec[4:0];
  assign acc_reg  = paddr[7:2];
  assign acc_hit  = (paddr[1:0] == 2'b00) && dec[5]
                    && (acc_reg == REG_SAMPLE || acc_reg == REG_CFG
                        || acc_reg == REG_TPL_CTRL || acc_reg == REG_TPL_READ);
  assign pready   = psel && penable;
  assign wr       = psel && penable && pwrite && acc_hit;
  assign ram_addr = ram_map(ctrl[acc_chan][CTRL_IDX_LSB +: 5]);
  assign ram_rd_en = ctrl[acc_chan][CTRL_ARB_BIT] && ctrl[acc_chan][CTRL_EN_BIT]
                     && ctrl[acc_chan][CTRL_DIR_BIT];
  assign ram_we   = wr && acc_reg == REG_SAMPLE
                    && ctrl[acc_chan][CTRL_ARB_BIT]
                    && ctrl[acc_chan][CTRL_EN_BIT] && !ctrl[acc_chan][CTRL_DIR_BIT];

  always_comb begin
    next_sample = sample;
    next_cfg    = cfg;
    next_ctrl   = ctrl;
    if (wr) begin
      unique case (acc_reg)
        REG_SAMPLE:   next_sample[acc_chan] = pwdata[6:0];
        REG_CFG:      next_cfg[acc_chan] = pwdata[7:0];
        REG_TPL_CTRL: next_ctrl[acc_chan] = {pwdata[11:8], 1'b0, pwdata[6:0]};
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    if (acc_hit) begin
      unique case (acc_reg)
        REG_SAMPLE:   rd_value = {25'h0000000, sample[acc_chan]};
        REG_CFG:      rd_value = {24'h000000, cfg[acc_chan]};
        REG_TPL_CTRL: rd_value = {20'h00000, ctrl[acc_chan]};
        REG_TPL_READ: rd_value = ram_rd_en ? {25'h0000000, ram[acc_chan][ram_addr]} : 32'h0;
        default: ;
      endcase
    end
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (psel && !penable) begin
      next_prdata  = pwrite ? 32'h0000_0000 : rd_value;
      next_pslverr = !acc_hit;
    end
    next_tpl_rd_data = 7'h00;
    if (tpl_rd_chan <= LAST_CHAN_BLK + 5'h01) begin
      next_tpl_rd_data = ram[tpl_rd_chan][ram_map(tpl_rd_addr)];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        sample[c] <= SAMPLE_RST;
        cfg[c]    <= CFG_RST;
        ctrl[c]   <= CTRL_RST;
      end
      prdata      <= 32'h0000_0000;
      pslverr     <= 1'b0;
      tpl_rd_data <= 7'h00;
      ref_meta    <= 1'b0;
      ref_sync    <= 1'b0;
    end else begin
      sample      <= next_sample;
      cfg         <= next_cfg;
      ctrl        <= next_ctrl;
      prdata      <= next_prdata;
      pslverr     <= next_pslverr;
      tpl_rd_data <= next_tpl_rd_data;
      ref_meta    <= reference_master_clock;
      ref_sync    <= ref_meta;
    end
  end

  // The template RAM has no reset; its contents are defined by software loading.
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram[acc_chan][ram_addr] <= pwdata[6:0];
    end
  end

  generate
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      assign rx_power_down[g]       = cfg[g][CFG_OFF_BIT];
      assign single_ended_rx[g]     = cfg[g][CFG_SING_BIT];
      assign full_internal_match[g] = cfg[g][CFG_FULL_BIT] && !cfg[g][CFG_SING_BIT]
                                      && per_channel_match_en;
      assign rx_match_mode[g]       = match_decode(cfg[g]);

      e1rc_rx_out u_rx_out (
        .clk                     (clk),
        .reset_n                 (reset_n),
        .ref_clock_sync          (ref_sync),
        .line_signal_loss        (line_signal_loss[g]),
        .rx_alarm_pattern_on     (rx_alarm_pattern_on[g]),
        .rx_recovered_clock_in   (rx_recovered_clock_in[g]),
        .rx_positive_rail_in     (rx_positive_rail_in[g]),
        .rx_negative_rail_in     (rx_negative_rail_in[g]),
        .rx_multifunction_in     (rx_multifunction_in[g]),
        .clock_hold_high_on_loss (cfg[g][CFG_HOLD_BIT]),
        .rx_outputs_float        (cfg[g][CFG_FLOAT_BIT]),
        .rx_power_down           (cfg[g][CFG_OFF_BIT]),
        .recovered_clock_out     (recovered_clock_out[g]),
        .rx_positive_rail_out    (rx_positive_rail_out[g]),
        .rx_negative_rail_out    (rx_negative_rail_out[g]),
        .rx_multifunction_out    (rx_multifunction_out[g]),
        .rx_outputs_oe           (rx_outputs_oe[g])
      );
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_chan0_cfg_write: assert property (
    wr && paddr == {CHAN0_BLK, REG_CFG, 2'b00} |=> cfg[0] == $past(pwdata[7:0]))
    else $error("channel 0 configuration write missed");

  a_chan21_sample_write: assert property (
    wr && paddr == {1'b0, LAST_CHAN_BLK, REG_SAMPLE, 2'b00}
    |=> sample[21] == $past(pwdata[6:0]))
    else $error("channel 21 sample write missed");

  a_ram_write_gate: assert property (
    ram_we |-> ctrl[acc_chan][CTRL_TPL_LSB+3] && psel && penable && pwrite
               && paddr[1:0] == 2'b00 && paddr[7:2] == REG_SAMPLE)
    else $error("template RAM written without arbitrary template");

  a_ram_dir_gate: assert property (
    ram_we |-> ctrl[acc_chan][CTRL_EN_BIT] && !ctrl[acc_chan][CTRL_DIR_BIT])
    else $error("template RAM written while access disabled or reading");

  a_ram_store_word: assert property (
    ram_we ##1 !ram_we |-> ram[$past(acc_chan, 1)][$past(ram_addr, 1)] == $past(pwdata[6:0], 1))
    else $error("template RAM word not stored at sample index");

  a_ram_index_clip: assert property (
    tpl_rd_addr >= RAM_LAST && tpl_rd_chan == 5'h03 && !ram_we
    |=> tpl_rd_data == ram[3][RAM_LAST])
    else $error("high sample index not mapped to last location");

  a_sample_hold: assert property (
    !$stable(sample[0]) |-> $past(wr && acc_chan == 5'h00 && acc_reg == REG_SAMPLE))
    else $error("sample register changed without a write");

  a_reserved_zero: assert property (
    psel && penable && !pwrite && acc_hit && (acc_reg == REG_SAMPLE || acc_reg == REG_CFG)
    |-> prdata[31:8] == 24'h000000 && (acc_reg != REG_SAMPLE || !prdata[7]))
    else $error("reserved bits read nonzero");

  a_power_down_bit: assert property (
    wr && acc_chan == 5'h07 && acc_reg == REG_CFG
    |=> rx_power_down[7] == $past(pwdata[CFG_OFF_BIT]))
    else $error("power-down bit not applied");

  a_single_external: assert property (
    single_ended_rx[0] |-> rx_match_mode[0] == MATCH_EXTERNAL && !full_internal_match[0])
    else $error("single-ended channel not on external matching");

  a_full_match_cond: assert property (
    full_internal_match[0] |-> per_channel_match_en && !single_ended_rx[0])
    else $error("full internal match outside differential per-channel mode");

  a_unmapped_err: assert property (
    psel && !penable && !acc_hit ##1 psel && penable |-> pslverr)
    else $error("unmapped access without error");

  a_hit_no_error: assert property (
    psel && !penable && acc_hit
    |=> !pslverr)
    else $error("mapped access flagged as error");

  a_bad_write_ignored: assert property (
    psel && penable && pwrite && !acc_hit
    |=> $stable(sample[1]) && $stable(cfg[1]))
    else $error("unmapped write changed a register");

  a_sample_write_word: assert property (
    wr && acc_reg == REG_SAMPLE
    |=> sample[$past(acc_chan)] == $past(pwdata[6:0]))
    else $error("sample register not loaded by write");

  a_cfg_readback: assert property (
    psel && !penable && !pwrite && acc_hit && acc_reg == REG_CFG
    |=> prdata == {24'h000000, cfg[$past(acc_chan)]})
    else $error("configuration read returned wrong data");

  a_ctrl_reserved: assert property (
    !ctrl[3][7] && !ctrl[0][7])
    else $error("reserved template control bit set");

  a_tpl_read_gate: assert property (
    psel && !penable && !pwrite && acc_reg == REG_TPL_READ && !ctrl[acc_chan][CTRL_EN_BIT]
    |=> prdata == 32'h0000_0000)
    else $error("template RAM read while access disabled");

  a_tpl_read_data: assert property (
    psel && !penable && !pwrite && acc_hit && acc_reg == REG_TPL_READ && ram_rd_en
    |=> prdata == {25'h0000000, ram[$past(acc_chan)][$past(ram_addr)]})
    else $error("template RAM read returned wrong word");

  a_tpl_port_range: assert property (
    tpl_rd_chan > LAST_CHAN_BLK + 5'h01
    |=> tpl_rd_data == 7'h00)
    else $error("template read port answered for a missing channel");

  a_match_120: assert property (
    !cfg[0][CFG_SING_BIT] && cfg[0][CFG_TERM_LSB +: 3] == 3'b010
    |-> rx_match_mode[0] == MATCH_INT_120)
    else $error("match select 010 not decoded as 120 ohm internal");

  a_match_75: assert property (
    !cfg[0][CFG_SING_BIT] && cfg[0][CFG_TERM_LSB +: 3] == 3'b011
    |-> rx_match_mode[0] == MATCH_INT_75)
    else $error("match select 011 not decoded as 75 ohm internal");

  a_match_ext: assert property (
    cfg[0][CFG_TERM_LSB+2]
    |-> rx_match_mode[0] == MATCH_EXTERNAL)
    else $error("match select 1xx not decoded as external");

endmodule

// file: e1rc_rx_out.sv
`timescale 1ns/1ps
module e1rc_rx_out
  import e1rc_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset_n,
  // Receive path signals.
  input  wire logic ref_clock_sync,
  input  wire logic line_signal_loss,
  input  wire logic rx_alarm_pattern_on,
  input  wire logic rx_recovered_clock_in,
  input  wire logic rx_positive_rail_in,
  input  wire logic rx_negative_rail_in,
  input  wire logic rx_multifunction_in,
  // Channel configuration.
  input  wire logic clock_hold_high_on_loss,
  input  wire logic rx_outputs_float,
  input  wire logic rx_power_down,
  // System side outputs.
  output logic      recovered_clock_out,
  output logic      rx_positive_rail_out,
  output logic      rx_negative_rail_out,
  output logic      rx_multifunction_out,
  output logic      rx_outputs_oe
);

  logic next_clk_out;
  logic next_pos;
  logic next_neg;
  logic next_mf;
  logic next_oe;
  logic clk_src;

  always_comb begin
    clk_src = rx_recovered_clock_in;
    if (line_signal_loss && !rx_alarm_pattern_on) begin
      clk_src = clock_hold_high_on_loss ? 1'b1 : ref_clock_sync;
    end
    if (rx_power_down) begin
      next_clk_out = 1'b0;
      next_pos     = 1'b0;
      next_neg     = 1'b0;
      next_mf      = 1'b0;
      next_oe      = !rx_outputs_float;
    end else begin
      next_clk_out = clk_src;
      next_pos     = rx_positive_rail_in;
      next_neg     = rx_negative_rail_in;
      next_mf      = rx_multifunction_in;
      next_oe      = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      recovered_clock_out  <= 1'b0;
      rx_positive_rail_out <= 1'b0;
      rx_negative_rail_out <= 1'b0;
      rx_multifunction_out <= 1'b0;
      rx_outputs_oe        <= 1'b0;
    end else begin
      recovered_clock_out  <= next_clk_out;
      rx_positive_rail_out <= next_pos;
      rx_negative_rail_out <= next_neg;
      rx_multifunction_out <= next_mf;
      rx_outputs_oe        <= next_oe;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_loss_clock_high: assert property (
    line_signal_loss && !rx_alarm_pattern_on && clock_hold_high_on_loss && !rx_power_down
    |=> recovered_clock_out && rx_outputs_oe)
    else $error("clock not held high during signal loss");

  a_loss_clock_ref: assert property (
    line_signal_loss && !rx_alarm_pattern_on && !clock_hold_high_on_loss && !rx_power_down
    |=> recovered_clock_out == $past(ref_clock_sync))
    else $error("clock does not follow reference during signal loss");

  a_pd_drive_low: assert property (
    rx_power_down && !rx_outputs_float
    |=> rx_outputs_oe && !recovered_clock_out && !rx_positive_rail_out
        && !rx_negative_rail_out && !rx_multifunction_out)
    else $error("powered-down outputs not driven low");

  a_pd_float_out: assert property (
    rx_power_down && rx_outputs_float |=> !rx_outputs_oe)
    else $error("powered-down outputs not floating");

endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  import e1rc_pkg::*;
  logic                       clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [13:0]                paddr;
  logic [31:0]                pwdata, prdata, rdv;
  logic                       pcm_en, ref_clk, rerr;
  logic [NUM_CHAN-1:0]        los, alarm, rclk_in, pos_in, neg_in, mf_in;
  logic [NUM_CHAN-1:0]        rclk_out, pos_out, neg_out, mf_out, oe, pdn, sing, full;
  e1rc_match_t [NUM_CHAN-1:0] mode;
  logic [4:0]                 rd_chan, rd_addr;
  logic [6:0]                 rd_data;
  int                         error_cnt, n_compared;

  e1rc_apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  e1rc_regs dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .per_channel_match_en(pcm_en), .reference_master_clock(ref_clk),
    .line_signal_loss(los), .rx_alarm_pattern_on(alarm), .rx_recovered_clock_in(rclk_in),
    .rx_positive_rail_in(pos_in), .rx_negative_rail_in(neg_in),
    .rx_multifunction_in(mf_in), .recovered_clock_out(rclk_out),
    .rx_positive_rail_out(pos_out), .rx_negative_rail_out(neg_out),
    .rx_multifunction_out(mf_out), .rx_outputs_oe(oe), .rx_power_down(pdn),
    .single_ended_rx(sing), .full_internal_match(full), .rx_match_mode(mode),
    .tpl_rd_chan(rd_chan), .tpl_rd_addr(rd_addr), .tpl_rd_data(rd_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [13:0] ba(input int ch, input logic [5:0] idx);
    logic [11:0] base;
    base = (ch == 0) ? 12'h7c0 : 12'((ch - 1) * 64);
    return {base + {6'h00, idx}, 2'b00};
  endfunction

  task automatic wr(input int ch, input logic [5:0] idx, input logic [31:0] d);
    u_host.xfer(1'b1, ba(ch, idx), d, rdv, rerr);
  endtask

  task automatic rdchk(input int ch, input logic [5:0] idx, input logic [31:0] e);
    u_host.xfer(1'b0, ba(ch, idx), 32'h0000_0000, rdv, rerr);
    `CHK(rdv, e)
    `CHK(rerr, 1'b0)
  endtask

  // Lets the registered outputs settle, then samples away from the clock edge.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic tport(input logic [4:0] ch, input logic [4:0] a, input logic [6:0] e);
    @(posedge clk);
    rd_chan <= ch;
    rd_addr <= a;
    settle(1);
    `CHK(rd_data, e)
  endtask

  task automatic t_defaults();
    int chs[3] = '{0, 1, 21};
    foreach (chs[i]) begin
      rdchk(chs[i], REG_CFG, 32'h0000_0047);
      rdchk(chs[i], REG_SAMPLE, 32'h0000_0000);
    end
    `CHK(oe, {NUM_CHAN{1'b1}})
    `CHK(mode[21], MATCH_EXTERNAL)
  endtask

  task automatic t_sample();
    wr(5, REG_SAMPLE, 32'hffff_ffd5);
    rdchk(5, REG_SAMPLE, 32'h0000_0055);
    rdchk(6, REG_SAMPLE, 32'h0000_0000);
    rdchk(4, REG_SAMPLE, 32'h0000_0000);
    wr(0, REG_SAMPLE, 32'h0000_002a);
    wr(21, REG_SAMPLE, 32'h0000_00b3);
    rdchk(0, REG_SAMPLE, 32'h0000_002a);
    rdchk(21, REG_SAMPLE, 32'h0000_0033);
    wr(5, REG_CFG, 32'hffff_ff47);
    rdchk(5, REG_CFG, 32'h0000_0047);
    rdchk(5, REG_SAMPLE, 32'h0000_0055);
    u_host.xfer(1'b1, 14'h0025, 32'h0000_0011, rdv, rerr);
    `CHK(rerr, 1'b1)
    rdchk(1, REG_SAMPLE, 32'h0000_0000);
    u_host.xfer(1'b0, ba(1, 6'h20), 32'h0000_0000, rdv, rerr);
    `CHK(rerr, 1'b1)
    `CHK(rdv, 32'h0000_0000)
  endtask

  task automatic t_ram();
    logic [4:0] idx[4] = '{5'd0, 5'd18, 5'd19, 5'd25};
    foreach (idx[i]) begin
      wr(3, REG_TPL_CTRL, 32'h0000_0840 | 32'(idx[i]));
      wr(3, REG_SAMPLE, 32'(8'd11 * (i + 1)));
    end
    tport(5'd3, 5'd0, 7'd11);
    tport(5'd3, 5'd18, 7'd22);
    tport(5'd3, 5'd19, 7'd44);
    tport(5'd3, 5'd31, 7'd44);
    tport(5'd25, 5'd19, 7'd0);
    wr(3, REG_TPL_CTRL, 32'h0000_0040);
    wr(3, REG_SAMPLE, 32'h0000_007f);
    tport(5'd3, 5'd0, 7'd11);
    wr(3, REG_TPL_CTRL, 32'h0000_0800);
    wr(3, REG_SAMPLE, 32'h0000_007e);
    tport(5'd3, 5'd0, 7'd11);
    rdchk(3, REG_TPL_READ, 32'h0000_0000);
    wr(3, REG_TPL_CTRL, 32'h0000_08f2);
    rdchk(3, REG_TPL_CTRL, 32'h0000_0872);
    rdchk(3, REG_TPL_READ, 32'h0000_0016);
  endtask

  task automatic t_clock();
    @(posedge clk);
    los[2] <= 1'b1;
    wr(2, REG_CFG, 32'h0000_00c7);
    settle(3);
    `CHK(rclk_out[2], 1'b1)
    wr(2, REG_CFG, 32'h0000_0047);
    settle(3);
    `CHK(rclk_out[2], 1'b0)
    @(posedge clk);
    ref_clk <= 1'b1;
    settle(4);
    `CHK(rclk_out[2], 1'b1)
    @(posedge clk);
    alarm[2] <= 1'b1;
    wr(2, REG_CFG, 32'h0000_00c7);
    settle(3);
    `CHK(rclk_out[2], 1'b0)
  endtask

  task automatic t_power();
    wr(7, REG_CFG, 32'h0000_0067);
    settle(3);
    `CHK({oe[7], pos_out[7], neg_out[7], mf_out[7], rclk_out[7], pdn[7]}, 6'b000001)
    wr(7, REG_CFG, 32'h0000_0027);
    settle(3);
    `CHK({oe[7], pos_out[7], neg_out[7], mf_out[7], rclk_out[7]}, 5'b10000)
    wr(7, REG_CFG, 32'h0000_0007);
    settle(3);
    `CHK({oe[7], pos_out[7], neg_out[7], mf_out[7], rclk_out[7], pdn[7]}, 6'b111110)
  endtask

  task automatic t_match();
    e1rc_match_t e;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 8; c++) begin
        wr(0, REG_CFG, 32'h10 | 32'(s * 8) | 32'(c));
        e = (s == 1 || c >= 4) ? MATCH_EXTERNAL : (c == 2) ? MATCH_INT_120 :
            (c == 3) ? MATCH_INT_75 : MATCH_RESERVED;
        settle(1);
        `CHK(mode[0], e)
        `CHK(sing[0], s[0])
        `CHK(full[0], !s[0])
      end
    end
    @(posedge clk);
    pcm_en <= 1'b0;
    wr(0, REG_CFG, 32'h0000_0017);
    settle(1);
    `CHK(full[0], 1'b0)
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(25ns * 20000);
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    reset_n = 1'b0;
    pcm_en = 1'b1;
    ref_clk = 1'b0;
    los = '0;
    alarm = '0;
    rclk_in = 22'h3ffffb;
    pos_in = '1;
    neg_in = '1;
    mf_in = '1;
    rd_chan = 5'h00;
    rd_addr = 5'h00;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_defaults();
    t_sample();
    t_ram();
    t_clock();
    t_power();
    t_match();
    report_and_stop();
  end
endmodule
